// >>> logic/tcs_pkg.sv
package tcs_pkg;
  // Clock rate
  localparam int CLK_MHZ = 100;
  localparam int CLK_KHZ = 100000;
  // Times as specified
  localparam int T_RESET_US = 10;
  localparam int T_SERIAL_MS = 300;
  localparam int T_DATA_MS = 1000;
  localparam int T_WRITE_MS = 10;
  localparam int T_MIRROR_US = 1000;
  localparam int F_SCL_KHZ = 400;
  // Cycle counts derived from the times
  localparam int T_RESET_CYC = T_RESET_US * CLK_MHZ;
  localparam int T_SERIAL_CYC = T_SERIAL_MS * CLK_KHZ;
  localparam int T_DATA_CYC = T_DATA_MS * CLK_KHZ;
  localparam int T_WRITE_CYC = T_WRITE_MS * CLK_KHZ;
  localparam int T_MIRROR_CYC = T_MIRROR_US * CLK_MHZ;
  // Quarter serial clock, rounded up so the bus never runs too fast
  localparam int SCL_Q_CYC = (CLK_KHZ + 4 * F_SCL_KHZ - 1) / (4 * F_SCL_KHZ);
  // Two-wire addresses and memory map
  localparam logic [6:0] ID_DEV = 7'h50;
  localparam logic [6:0] DIAG_DEV = 7'h51;
  localparam logic [7:0] TRAITS_BYTE = 8'h41;
  localparam logic [7:0] TRAITS_VAL = 8'h3A;
  localparam logic [7:0] STAT_BYTE = 8'h6E;
  localparam int SOFT_OFF_BIT = 6;
  // Host register offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] XFER_OFS = 4'h8;
  localparam logic [3:0] RDATA_OFS = 4'hC;
  // Transfer register fields
  localparam int XF_DAT_LSB = 8;
  localparam int XF_DIAG_BIT = 16;
  localparam int XF_READ_BIT = 17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Device two-wire states
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0, DS_DEV = 3'h1, DS_WADR = 3'h3,
    DS_WDAT = 3'h2, DS_RDAT = 3'h6
  } tcs_dst_t;
  // Host two-wire states
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0, HS_STRT = 3'h1, HS_BYTE = 3'h3,
    HS_STOP = 3'h2, HS_WAIT = 3'h6
  } tcs_hst_t;
endpackage

// >>> logic/tcs_if.sv
`timescale 1ns/100ps
interface tcs_if;
  logic tx_off_req;
  logic tx_fault;
  logic receive_signal_lost;
  logic scl;
  logic h_sda_o;
  logic h_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  wire sda;
  // Open-drain data line, high unless someone pulls it
  assign sda = (h_sda_oe_n | h_sda_o) & (d_sda_oe_n | d_sda_o);
  modport dev (
    input tx_off_req, scl, sda,
    output tx_fault, receive_signal_lost, d_sda_o, d_sda_oe_n
  );
  modport host (
    output tx_off_req, scl, h_sda_o, h_sda_oe_n,
    input tx_fault, receive_signal_lost, sda
  );
endinterface

// >>> logic/tcs_sync.sv
`timescale 1ns/100ps
module tcs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Raw and synchronised levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // Two flops; the first feeds only the second
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// >>> logic/tcs_dev.sv
`timescale 1ns/100ps
module tcs_dev #(
  parameter logic [31:0] T_SERIAL_CYC = 32'(tcs_pkg::T_SERIAL_CYC),
  parameter logic [31:0] T_DATA_CYC = 32'(tcs_pkg::T_DATA_CYC),
  parameter logic [31:0] T_MIRROR_CYC = 32'(tcs_pkg::T_MIRROR_CYC)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Link to the host board
  tcs_if.dev link,
  // Optical front end
  input wire logic fault_detect,
  input wire logic pp_signal_ok,
  output logic laser_enable
);
  logic [4:0] raw;
  logic [4:0] syn;
  logic hw_off;
  logic flt_in;
  logic sig_in;
  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;
  logic [31:0] por_q;
  logic [31:0] mir_q;
  logic [15:0] off_q;
  logic hw_off_p_q;
  logic fault_q;
  logic los_q;
  logic flt_mir_q;
  logic los_mir_q;
  logic laser_q;
  tcs_pkg::tcs_dst_t st_q;
  tcs_pkg::tcs_dst_t st_nx;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic drv_q;
  logic ack_q;
  logic rd_q;
  logic dsel_q;
  logic [7:0] ptr_q;
  logic pend_q;
  logic pval_q;
  logic soft_off_q;

  // All pins cross into the local clock first
  assign raw = {link.tx_off_req, fault_detect, pp_signal_ok,
                link.scl, link.sda};
  tcs_sync #(.W(5), .INIT(5'h03)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d(raw),
    .q(syn)
  );
  assign hw_off = syn[4];
  assign flt_in = syn[3];
  assign sig_in = syn[2];
  assign scl_s = syn[1];
  assign sda_s = syn[0];

  // Bus event decode
  wire bus_rdy = por_q >= T_SERIAL_CYC;
  wire drdy = por_q >= T_DATA_CYC;
  wire ev_start = scl_s & scl_p_q & sda_p_q & !sda_s;
  wire ev_stop = scl_s & scl_p_q & !sda_p_q & sda_s;
  wire ev_rise = scl_s & !scl_p_q;
  wire ev_fall = !scl_s & scl_p_q;
  wire active = st_q != tcs_pkg::DS_IDLE;
  wire end_dat = active & ev_fall & (cnt_q == 4'h7);
  wire end_ack = active & ev_fall & (cnt_q == 4'h8);
  wire addr_hit = (sh_q[7:1] == tcs_pkg::ID_DEV) |
                  (sh_q[7:1] == tcs_pkg::DIAG_DEV);
  wire ack_ok = (st_q != tcs_pkg::DS_DEV) | addr_hit;
  wire off_long = off_q >= 16'(tcs_pkg::T_RESET_CYC);
  wire mir_tick = mir_q == T_MIRROR_CYC - 32'h1;

  // Status byte: bit6 soft off, bit2 fault, bit1 loss, bit0 ready
  wire [7:0] stat_b = {1'b0, soft_off_q, 3'h0, flt_mir_q, los_mir_q, drdy};
  wire [7:0] diag_b = (ptr_q == tcs_pkg::STAT_BYTE) ? stat_b : 8'h00;
  wire [7:0] id_b = (ptr_q == tcs_pkg::TRAITS_BYTE) ?
                    tcs_pkg::TRAITS_VAL : 8'h00;
  wire [7:0] rbyte = dsel_q ? diag_b : id_b;

  // Power-on timer for bus readiness and monitor data
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      por_q <= 32'h0;
    end else if (!drdy) begin
      por_q <= por_q + 32'h1;
    end
  end

  // Periodic sampler for the soft status copies
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mir_q <= 32'h0;
      flt_mir_q <= 1'b0;
      los_mir_q <= 1'b1;
    end else begin
      mir_q <= mir_tick ? 32'h0 : mir_q + 32'h1;
      if (mir_tick) begin
        flt_mir_q <= fault_q;
        los_mir_q <= los_q;
      end
    end
  end

  // How long the hardware off request has been held
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      off_q <= 16'h0;
      hw_off_p_q <= 1'b0;
    end else begin
      hw_off_p_q <= hw_off;
      if (!hw_off) begin
        off_q <= 16'h0;
      end else if (!off_long) begin
        off_q <= off_q + 16'h1;
      end
    end
  end

  // Fault latch; a new fault beats the release that would clear it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fault_q <= 1'b0;
    end else if (flt_in) begin
      fault_q <= 1'b1;
    end else if (hw_off_p_q & !hw_off & off_long) begin
      fault_q <= 1'b0;
    end
  end

  // Laser gating and loss pin, a few cycles from the pins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      laser_q <= 1'b0;
      los_q <= 1'b1;
    end else begin
      laser_q <= !(hw_off | soft_off_q | fault_q);
      los_q <= !sig_in;
    end
  end
  assign laser_enable = laser_q;
  assign link.tx_fault = fault_q;
  assign link.receive_signal_lost = los_q;
  assign link.d_sda_o = 1'b0;
  assign link.d_sda_oe_n = !drv_q;

  // Next byte phase after an acknowledge slot
  always_comb begin
    case (st_q)
      tcs_pkg::DS_DEV: begin
        if (!ack_q) begin
          st_nx = tcs_pkg::DS_IDLE;
        end else begin
          st_nx = rd_q ? tcs_pkg::DS_RDAT : tcs_pkg::DS_WADR;
        end
      end
      tcs_pkg::DS_WADR: st_nx = tcs_pkg::DS_WDAT;
      tcs_pkg::DS_WDAT: st_nx = tcs_pkg::DS_WDAT;
      tcs_pkg::DS_RDAT: begin
        st_nx = ack_q ? tcs_pkg::DS_RDAT : tcs_pkg::DS_IDLE;
      end
      default: st_nx = tcs_pkg::DS_IDLE;
    endcase
  end

  // Bus state and bit count; starts ignored until the bus is ready
  always_ff @(posedge clock) begin
    if (!rst_n || ev_stop) begin
      st_q <= tcs_pkg::DS_IDLE;
      cnt_q <= 4'h0;
    end else if (ev_start & bus_rdy) begin
      st_q <= tcs_pkg::DS_DEV;
      cnt_q <= 4'hF; // Clock fall after the start wraps to zero
    end else if (end_ack) begin
      st_q <= st_nx;
      cnt_q <= 4'h0;
    end else if (active & ev_fall) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // Line sampling on rise, line driving on fall
  always_ff @(posedge clock) begin
    scl_p_q <= rst_n ? scl_s : 1'b1;
    sda_p_q <= rst_n ? sda_s : 1'b1;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sh_q <= 8'h00;
      drv_q <= 1'b0;
      ack_q <= 1'b0;
      rd_q <= 1'b0;
      dsel_q <= 1'b0;
    end else if (ev_start | ev_stop) begin
      drv_q <= 1'b0;
    end else if (active & ev_rise) begin
      if (cnt_q != 4'h8 && st_q != tcs_pkg::DS_RDAT) begin
        sh_q <= {sh_q[6:0], sda_s};
      end
      if (cnt_q == 4'h8 && st_q == tcs_pkg::DS_RDAT) begin
        ack_q <= !sda_s;
      end
    end else if (end_dat) begin
      drv_q <= (st_q != tcs_pkg::DS_RDAT) & ack_ok;
      ack_q <= ack_ok;
      if (st_q == tcs_pkg::DS_DEV) begin
        rd_q <= sh_q[0];
        dsel_q <= sh_q[1];
      end
    end else if (end_ack) begin
      if (st_nx == tcs_pkg::DS_RDAT) begin
        sh_q <= rbyte;
        drv_q <= !rbyte[7];
      end else begin
        drv_q <= 1'b0;
      end
    end else if (active & ev_fall & st_q == tcs_pkg::DS_RDAT) begin
      sh_q <= {sh_q[6:0], 1'b0};
      drv_q <= !sh_q[6];
    end
  end

  // Byte pointer, set by the address byte and stepped at each data byte; soft off bit, committed at the stop
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ptr_q <= 8'h00;
      pend_q <= 1'b0;
      pval_q <= 1'b0;
      soft_off_q <= 1'b0;
    end else if (ev_stop) begin
      if (pend_q) begin
        soft_off_q <= pval_q;
      end
      pend_q <= 1'b0;
    end else if (end_dat & st_q == tcs_pkg::DS_WADR) begin
      ptr_q <= sh_q;
    end else if (end_dat & st_q == tcs_pkg::DS_WDAT) begin
      ptr_q <= ptr_q + 8'h01;
      if (dsel_q & ptr_q == tcs_pkg::STAT_BYTE) begin
        pend_q <= 1'b1;
        pval_q <= sh_q[tcs_pkg::SOFT_OFF_BIT];
      end
    end else if (end_ack & st_nx == tcs_pkg::DS_RDAT) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end
endmodule

// >>> logic/tcs_host.sv
`timescale 1ns/100ps
module tcs_host #(
  parameter logic [31:0] T_SERIAL_CYC = 32'(tcs_pkg::T_SERIAL_CYC),
  parameter logic [31:0] T_WRITE_CYC = 32'(tcs_pkg::T_WRITE_CYC)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Link to the transceiver
  tcs_if.host link,
  // AXI4-Lite write channels
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  logic [2:0] syn;
  logic aw_q, w_q;
  logic [3:0] awa_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic ctrl_q, off_q;
  logic [15:0] hold_q;
  logic [31:0] por_q;
  tcs_pkg::tcs_hst_t st_q;
  logic [1:0] idx_q, ph_q;
  logic [3:0] bit_q;
  logic [7:0] qc_q, sh_q, rx_q, adr_q, dat_q;
  logic diag_q, rd_q, nack_q, scl_q, sdl_q;
  logic [31:0] wc_q;

  tcs_sync #(.W(3), .INIT(3'h3)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({link.tx_fault, link.receive_signal_lost, link.sda}),
    .q(syn)
  );

  // Register decode
  wire bus_rdy = por_q >= T_SERIAL_CYC;
  wire busy = st_q != tcs_pkg::HS_IDLE;
  wire wr_go = aw_q & w_q;
  wire is_ctrl = awa_q == tcs_pkg::CTRL_OFS;
  wire is_xfer = awa_q == tcs_pkg::XFER_OFS;
  wire xf_ok = !busy & bus_rdy;
  wire wr_xfer = wr_go & is_xfer & ws_q[0] & xf_ok;
  wire wr_err = !(is_ctrl | (is_xfer & xf_ok));
  wire [31:0] stat_w = {27'h0, bus_rdy, nack_q, busy, syn[1], syn[2]};
  wire ar_ok = araddr != tcs_pkg::XFER_OFS;
  wire [31:0] rd_mux = (araddr == tcs_pkg::CTRL_OFS) ? {31'h0, ctrl_q} :
                       (araddr == tcs_pkg::STATUS_OFS) ? stat_w :
                       (araddr == tcs_pkg::RDATA_OFS) ? {24'h0, rx_q} :
                       32'h0;
  assign awready = !aw_q & !bvalid;
  assign wready = !w_q & !bvalid;
  assign arready = !rvalid;

  // Write path: both halves in any order, then a response
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 4'h0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= tcs_pkg::RESP_OKAY;
    end else begin
      if (awvalid & awready) begin
        aw_q <= 1'b1;
        awa_q <= awaddr;
      end
      if (wvalid & wready) begin
        w_q <= 1'b1;
        wd_q <= wdata;
        ws_q <= wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_err ? tcs_pkg::RESP_SLVERR : tcs_pkg::RESP_OKAY;
      end else if (bvalid & bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read path, answered the cycle after the address is taken
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= tcs_pkg::RESP_OKAY;
    end else if (arvalid & arready) begin
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= ar_ok ? tcs_pkg::RESP_OKAY : tcs_pkg::RESP_SLVERR;
    end else if (rvalid & rready) begin
      rvalid <= 1'b0;
    end
  end

  // Off request pin stretched so a short pulse still resets a fault
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_q <= 1'b0;
      off_q <= 1'b0;
      hold_q <= 16'h0;
      por_q <= 32'h0;
    end else begin
      if (wr_go & is_ctrl & ws_q[0]) begin
        ctrl_q <= wd_q[0];
      end
      off_q <= ctrl_q | (off_q & hold_q < 16'(tcs_pkg::T_RESET_CYC));
      hold_q <= off_q ? hold_q + {15'h0, hold_q != 16'hFFFF} : 16'h0;
      if (!bus_rdy) begin
        por_q <= por_q + 32'h1;
      end
    end
  end
  assign link.tx_off_req = off_q;

  // Serial engine: quarter-period ticks of a slow serial clock
  wire tick = qc_q == 8'(tcs_pkg::SCL_Q_CYC - 1);
  wire rx_mode = idx_q == 2'h3;
  wire [6:0] dev = diag_q ? tcs_pkg::DIAG_DEV : tcs_pkg::ID_DEV;
  wire [7:0] tx_b = (idx_q == 2'h0) ? {dev, 1'b0} :
                    (idx_q == 2'h1) ? adr_q :
                    rd_q ? {dev, 1'b1} : dat_q;
  wire last = rd_q ? (idx_q == 2'h3) : (idx_q == 2'h2);
  wire data_bit = bit_q != 4'h8;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q <= tcs_pkg::HS_IDLE;
      {idx_q, ph_q, bit_q, qc_q, sh_q, rx_q} <= '0;
      {adr_q, dat_q, diag_q, rd_q, nack_q} <= '0;
      scl_q <= 1'b1;
      sdl_q <= 1'b0;
      wc_q <= 32'h0;
    end else if (wr_xfer) begin
      st_q <= tcs_pkg::HS_STRT;
      {idx_q, ph_q, bit_q, qc_q, nack_q} <= '0;
      adr_q <= wd_q[7:0];
      dat_q <= wd_q[tcs_pkg::XF_DAT_LSB +: 8];
      diag_q <= wd_q[tcs_pkg::XF_DIAG_BIT];
      rd_q <= wd_q[tcs_pkg::XF_READ_BIT];
    end else if (st_q == tcs_pkg::HS_WAIT) begin
      // Device write cycle must finish before the next transfer
      wc_q <= wc_q + 32'h1;
      if (wc_q == T_WRITE_CYC - 32'h1) begin
        st_q <= tcs_pkg::HS_IDLE;
      end
    end else if (busy) begin
      qc_q <= tick ? 8'h00 : qc_q + 8'h01;
      if (tick) begin
        ph_q <= ph_q + 2'h1;
        case (ph_q)
          2'h0: begin
            scl_q <= 1'b0;
            if (st_q == tcs_pkg::HS_BYTE) begin
              sdl_q <= data_bit & !rx_mode &
                       ((bit_q == 4'h0) ? !tx_b[7] : !sh_q[7]);
              if (bit_q == 4'h0) begin
                sh_q <= tx_b;
              end
            end else begin
              sdl_q <= st_q == tcs_pkg::HS_STOP;
            end
          end
          2'h1: scl_q <= 1'b1;
          2'h2: begin
            if (st_q != tcs_pkg::HS_BYTE) begin
              sdl_q <= st_q == tcs_pkg::HS_STRT;
            end else if (data_bit) begin
              sh_q <= {sh_q[6:0], syn[0]};
            end else if (!rx_mode) begin
              nack_q <= syn[0];
            end
          end
          default: begin
            if (st_q == tcs_pkg::HS_STOP) begin
              wc_q <= 32'h0;
              st_q <= (rd_q | nack_q) ? tcs_pkg::HS_IDLE :
                      tcs_pkg::HS_WAIT;
            end else begin
              // A start carries no bit, so the bit count waits for it
              scl_q <= 1'b0;
              if (st_q == tcs_pkg::HS_STRT) begin
                st_q <= tcs_pkg::HS_BYTE;
              end else begin
                bit_q <= data_bit ? bit_q + 4'h1 : 4'h0;
              end
              if (st_q == tcs_pkg::HS_BYTE && !data_bit) begin
                if (rx_mode) begin
                  rx_q <= sh_q;
                end
                idx_q <= idx_q + 2'h1;
                if (nack_q | last) begin
                  st_q <= tcs_pkg::HS_STOP;
                end else if (rd_q & idx_q == 2'h1) begin
                  st_q <= tcs_pkg::HS_STRT;
                end
              end
            end
          end
        endcase
      end
    end
  end
  assign link.scl = scl_q;
  assign link.h_sda_o = 1'b0;
  assign link.h_sda_oe_n = !sdl_q;
endmodule

// >>> tb/tcs_props.sv
`timescale 1ns/100ps
module tcs_props #(
  parameter int T_SERIAL_CYC = 2000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Link signals
  input wire logic tx_off_req,
  input wire logic tx_fault,
  input wire logic receive_signal_lost,
  input wire logic scl,
  input wire logic sda,
  input wire logic d_sda_oe_n,
  // Optical front end
  input wire logic fault_detect,
  input wire logic pp_signal_ok,
  input wire logic laser_enable
);
  localparam int T_PIN_CYC = 10000;
  localparam int T_SCL_MIN = 250;
  logic [15:0] flt_q, flt_d, los_q, los_d, per_q, per_d;
  logic [31:0] up_q, up_d;
  logic scl_q;
  logic scl_rise;

  // Lag counters: a pin that lags its cause too long shows as a big count
  assign flt_d = (fault_detect && !tx_fault) ? flt_q + 16'h1 : 16'h0;
  assign los_d = (receive_signal_lost == pp_signal_ok) ? los_q + 16'h1 : 16'h0;
  // Serial clock period, saturating so long idle gaps never wrap
  assign scl_rise = scl && !scl_q;
  assign per_d = scl_rise ? 16'h1 : (&per_q ? per_q : per_q + 16'h1);
  assign up_d = (up_q < T_SERIAL_CYC) ? up_q + 32'h1 : up_q;

  // Helper registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      {flt_q, los_q, up_q} <= '0;
      per_q <= 16'hFFFF;
      scl_q <= 1'b1;
    end else begin
      {flt_q, los_q, per_q, up_q} <= {flt_d, los_d, per_d, up_d};
      scl_q <= scl;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_off;
    tx_off_req [*8] |-> !laser_enable;
  endproperty
  a_off: assert property (p_off)
    else $error("light on while off request held");
  property p_fault_shut;
    fault_detect [*8] |-> !laser_enable;
  endproperty
  a_fault_shut: assert property (p_fault_shut)
    else $error("light on during fault");
  property p_fault_pin;
    flt_q < T_PIN_CYC;
  endproperty
  a_fault_pin: assert property (p_fault_pin)
    else $error("fault pin late");
  property p_los_pin;
    los_q < T_PIN_CYC;
  endproperty
  a_los_pin: assert property (p_los_pin)
    else $error("signal lost pin late");
  property p_latch;
    $fell(tx_fault) |-> $past(tx_off_req, 8);
  endproperty
  a_latch: assert property (p_latch)
    else $error("fault cleared without off request");
  property p_scl_rate;
    scl_rise |-> per_q >= T_SCL_MIN;
  endproperty
  a_scl_rate: assert property (p_scl_rate)
    else $error("serial clock too fast");
  property p_quiet;
    up_q < T_SERIAL_CYC |-> scl && sda;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("bus used before ready");
  property p_dev_sda;
    scl && $past(scl) |-> $stable(d_sda_oe_n);
  endproperty
  a_dev_sda: assert property (p_dev_sda)
    else $error("device moved data while clock high");
endmodule

// >>> tb/tcs_tb.sv
`timescale 1ns/100ps
module tcs_tb;
  localparam int LIMIT = 100000;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic fault_detect = 1'b0;
  logic pp_signal_ok = 1'b1;
  logic laser_enable;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  tcs_if link ();

  // 100 MHz clock
  always #5 clock = ~clock;

  tcs_dev #(.T_SERIAL_CYC(32'h7D0), .T_DATA_CYC(32'h1388),
    .T_MIRROR_CYC(32'h32)) i_tcs_dev (.clock(clock), .rst_n(rst_n),
    .link(link), .fault_detect(fault_detect),
    .pp_signal_ok(pp_signal_ok), .laser_enable(laser_enable));
  tcs_host #(.T_SERIAL_CYC(32'h7D0), .T_WRITE_CYC(32'hC8)) i_tcs_host (
    .clock(clock), .rst_n(rst_n), .link(link), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  tcs_props i_tcs_props (.clock(clock),
    .rst_n(rst_n), .tx_off_req(link.tx_off_req), .tx_fault(link.tx_fault),
    .receive_signal_lost(link.receive_signal_lost), .scl(link.scl), .sda(link.sda),
    .d_sda_oe_n(link.d_sda_oe_n), .fault_detect(fault_detect),
    .pp_signal_ok(pp_signal_ok), .laser_enable(laser_enable));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard, sized well above the expected run
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total = err_total + 1;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Handshakes judged at the rising edge, before its updates land
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic bh;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid & awready) awvalid <= 1'b0;
      if (wvalid & wready) wvalid <= 1'b0;
      bh = bvalid;
      r = bresp;
    end while (!bh);
    bready <= 1'b0;
    @(posedge clock);
  endtask

  // Read data taken at the edge where rvalid meets rready
  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic rh;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid & arready) arvalid <= 1'b0;
      rh = rvalid;
      d = rdata;
      r = rresp;
    end while (!rh);
    rready <= 1'b0;
    @(posedge clock);
  endtask

  // One two-wire byte transfer, polled to completion
  task automatic tw(input logic rdn, input logic dg, input logic [7:0] adr,
                    input logic [7:0] wd, output logic [7:0] q);
    logic [31:0] s;
    logic [1:0] r;
    wr(tcs_pkg::XFER_OFS, {14'h0, rdn, dg, wd, adr}, r);
    chk(r, 2'h0);
    do rd(tcs_pkg::STATUS_OFS, s, r); while (s[2] !== 1'b0);
    rd(tcs_pkg::RDATA_OFS, s, r);
    q = s[7:0];
    chk({link.scl, link.sda}, 2'b11);
  endtask

  task automatic t_boot;
    logic [31:0] s;
    logic [1:0] r;
    repeat (10) @(posedge clock);
    chk({laser_enable, link.tx_fault, link.receive_signal_lost}, 3'b100);
    rd(tcs_pkg::STATUS_OFS, s, r);
    chk(s[4:0], 5'h00);
    wr(tcs_pkg::XFER_OFS, 32'h0001_0041, r);
    chk(r, 2'h2);
    wr(tcs_pkg::STATUS_OFS, 32'h1, r);
    chk(r, 2'h2);
    rd(4'h2, s, r);
    chk(s, 32'h0);
    chk(r, 2'h0);
    repeat (2000) @(posedge clock);
    rd(tcs_pkg::STATUS_OFS, s, r);
    chk(s[4], 1'b1);
    $display("boot test done");
  endtask

  task automatic t_ident;
    logic [7:0] q;
    tw(1'b1, 1'b0, 8'h41, 8'h00, q);
    chk(q, 8'h3A);
    $display("ident test done");
  endtask

  task automatic t_hw_off;
    logic [1:0] r;
    wr(tcs_pkg::CTRL_OFS, 32'h1, r);
    repeat (12) @(posedge clock);
    chk({link.tx_off_req, laser_enable}, 2'b10);
    wr(tcs_pkg::CTRL_OFS, 32'h0, r);
    repeat (900) @(posedge clock);
    chk(link.tx_off_req, 1'b1);
    repeat (200) @(posedge clock);
    chk({link.tx_off_req, laser_enable}, 2'b01);
    $display("pin off test done");
  endtask

  task automatic t_soft;
    logic [7:0] q;
    logic [1:0] r;
    tw(1'b0, 1'b1, 8'h6E, 8'h40, q);
    chk(laser_enable, 1'b0);
    tw(1'b1, 1'b1, 8'h6E, 8'h00, q);
    chk(q, 8'h41);
    wr(tcs_pkg::CTRL_OFS, 32'h1, r);
    wr(tcs_pkg::CTRL_OFS, 32'h0, r);
    repeat (1100) @(posedge clock);
    chk(laser_enable, 1'b0);
    tw(1'b0, 1'b1, 8'h6E, 8'h00, q);
    repeat (10) @(posedge clock);
    chk(laser_enable, 1'b1);
    $display("soft off test done");
  endtask

  task automatic t_mirror;
    logic [7:0] q;
    logic [31:0] s;
    logic [1:0] r;
    fault_detect <= 1'b1;
    pp_signal_ok <= 1'b0;
    repeat (20) @(posedge clock);
    chk({link.tx_fault, link.receive_signal_lost, laser_enable}, 3'b110);
    rd(tcs_pkg::STATUS_OFS, s, r);
    chk(s[1:0], 2'b11);
    tw(1'b1, 1'b1, 8'h6E, 8'h00, q);
    chk(q, 8'h07);
    fault_detect <= 1'b0;
    pp_signal_ok <= 1'b1;
    repeat (20) @(posedge clock);
    chk({link.tx_fault, link.receive_signal_lost, laser_enable}, 3'b100);
    tw(1'b1, 1'b1, 8'h6E, 8'h00, q);
    chk(q, 8'h05);
    wr(tcs_pkg::CTRL_OFS, 32'h1, r);
    wr(tcs_pkg::CTRL_OFS, 32'h0, r);
    repeat (1100) @(posedge clock);
    chk({link.tx_fault, laser_enable}, 2'b01);
    $display("mirror test done");
  endtask

  // Reset for 10 cycles, then the scenarios in turn
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_boot();
    t_ident();
    t_hw_off();
    t_soft();
    t_mirror();
    wrap_up();
  end
endmodule
